// [common/dpt_pkg.sv]
// Constants shared by the dual programmable timer control block
package dpt_pkg;
   // ------------------------------------------------------------
   // Register addresses
   // ------------------------------------------------------------
   localparam logic [15:0] ADR_MODE = 16'hFFC0;
   localparam logic [15:0] ADR_SRC = 16'hFFC2;
   localparam logic [15:0] ADR_T0CTL = 16'hFFC3;
   localparam logic [15:0] ADR_T1CTL = 16'hFFC4;
   localparam logic [15:0] ADR_RLD0L = 16'hFFC6;
   localparam logic [15:0] ADR_RLD0H = 16'hFFC7;
   localparam logic [15:0] ADR_RLD1L = 16'hFFC8;
   localparam logic [15:0] ADR_RLD1H = 16'hFFC9;
   localparam logic [15:0] ADR_CNT0L = 16'hFFCC;
   localparam logic [15:0] ADR_CNT0H = 16'hFFCD;
   localparam logic [15:0] ADR_CNT1L = 16'hFFCE;
   localparam logic [15:0] ADR_CNT1H = 16'hFFCF;
   localparam logic [15:0] ADR_CMP0L = 16'hFFD2;
   localparam logic [15:0] ADR_CMP0H = 16'hFFD3;
   localparam logic [15:0] ADR_CMP1L = 16'hFFD4;
   localparam logic [15:0] ADR_CMP1H = 16'hFFD5;
   localparam logic [15:0] ADR_PWM = 16'hFFD8;
   localparam logic [15:0] ADR_MMASK = 16'hFFE0;
   localparam logic [15:0] ADR_UMASK = 16'hFFE1;
   localparam logic [15:0] ADR_MFLAG = 16'hFFF0;
   localparam logic [15:0] ADR_UFLAG = 16'hFFF1;
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int MODE_CASCADE_BIT = 3;
   localparam int MODE_EVENT_BIT = 2;
   localparam int MODE_FILTER_BIT = 1;
   localparam int MODE_POL_BIT = 0;
   localparam int CTL_RATIO_LSB = 2;
   localparam int CTL_RELOAD_BIT = 1;
   localparam int CTL_RUN_BIT = 0;
   // ------------------------------------------------------------
   // Reset values and counts
   // ------------------------------------------------------------
   localparam logic [3:0] NIB_RST = 4'h0;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [1:0] PAIR_RST = 2'h0;
   localparam logic [2:0] SYNC_RST = 3'h0;
   // Slow clock ticks per period of the 2,048 Hz filter reference
   localparam int REF_DIV = 16;
   localparam logic [3:0] REF_LAST = 4'(REF_DIV - 1);
   // Prescaler ratio codes
   localparam logic [1:0] RATIO_1 = 2'h0;
   localparam logic [1:0] RATIO_4 = 2'h1;
   localparam logic [1:0] RATIO_32 = 2'h2;
   localparam logic [1:0] RATIO_256 = 2'h3;
   // Noise rejector states
   typedef enum logic [1:0] {
      FLT_STABLE = 2'b01,
      FLT_ONE = 2'b10
   } dpt_flt_t;
endpackage

// [core/dpt_timer_core.sv]
// Dual 8-bit programmable timer control, cascade, event counter and flags
//
// Overview of operation
// - Source-select 0 feeds prescaler from slow clock, 1 from fast clock.
// - Timer 0 source ignored in event mode; timer 1 source ignored cascaded.
// - Ratio code 11 divides by 256, 10 by 32, 01 by 4, 00 by 1.
// - Timer 0 ratio ignored in event mode; timer 1 ratio ignored cascaded.
// - Cascade bit 1 forms 16-bit counter, timer 0 low byte, timer 1 high.
// - Cascaded counter is run and reloaded through timer 0 control registers.
// - Cascade bit 0 gives two independent 8-bit timers with own settings.
// - Timer 0 counts pin pulses when event mode set, else prescaled clock.
// - Filter accepts a pin level change at second 2,048 Hz falling edge.
// - Filtered pulses of 0.98 ms pass; glitches of 0.48 ms are dropped.
// - Filter off: timer 0 counts straight on the pin's edges.
// - Filter and polarity bits matter only in event mode.
// - Polarity 0 counts falling pin edges, polarity 1 rising edges.
// - Reset clears all configuration, compare, mask and flag bits.
// - PWM select bit 1 per timer picks PWM output, 0 normal; timer 0 bit serves both when cascaded; read/write.
// - Per-timer compare-match interrupt enable, 1 enables, 0 masks.
// - Per-timer underflow interrupt enable, 1 enables, 0 masks.
// - Underflow flag reads 1 after event; writing 1 clears, 0 no effect.
// - Match flag reads 1 after match; writing 1 clears, 0 no effect.
// - Upper bits D3 and D2 of PWM, mask and flag registers read 0.
// - Each compare value is two read/write nibbles, low and high.
// - Flags are set on their events even while masked.
// - PWM mode raises compare match when counter equals compare value.
// - Counters count down, reloading on underflow and on reload strobe.
`timescale 1ns/10ps
module dpt_timer_core (
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic [15:0] addr_i,
   input wire logic [3:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic slow_clock_i,
   input wire logic fast_clock_i,
   input wire logic external_count_pin_i,
   output logic [3:0] rdata_o,
   output logic t0_out_o,
   output logic t1_out_o,
   output logic int_request_o
);
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Prescaler terminal count for the chosen ratio
   function automatic logic dpt_ratio_hit(input logic [7:0] cnt, input logic [1:0] code);
      logic hit;
      hit = 1'b0;
      case (code)
         dpt_pkg::RATIO_1: hit = 1'b1;
         dpt_pkg::RATIO_4: hit = &cnt[1:0];
         dpt_pkg::RATIO_32: hit = &cnt[4:0];
         dpt_pkg::RATIO_256: hit = &cnt;
         default: hit = 1'b0;
      endcase
      return hit;
   endfunction

   // Write of a 1 into a given bit of a given register
   function automatic logic dpt_wr1(input logic wr, input logic [15:0] a,
                                    input logic [15:0] tgt, input logic b);
      return wr && (a == tgt) && b;
   endfunction

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic [2:0] s1_r, s2_r, s3_r, lvl_r, lvl_d_r;
   logic [2:0] s1_nxt, s2_nxt, s3_nxt, lvl_nxt;
   logic slow_rise, fast_rise, ext_lvl;

   // Three stages; level moves once stages two and three agree
   always_comb
   begin
      s1_nxt = {external_count_pin_i, fast_clock_i, slow_clock_i};
      s2_nxt = s1_r;
      s3_nxt = s2_r;
      lvl_nxt = (s2_r & s3_r) | (lvl_r & (s2_r | s3_r));
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         s1_r <= dpt_pkg::SYNC_RST;
         s2_r <= dpt_pkg::SYNC_RST;
         s3_r <= dpt_pkg::SYNC_RST;
         lvl_r <= dpt_pkg::SYNC_RST;
         lvl_d_r <= dpt_pkg::SYNC_RST;
      end
      else
      begin
         s1_r <= s1_nxt;
         s2_r <= s2_nxt;
         s3_r <= s3_nxt;
         lvl_r <= lvl_nxt;
         lvl_d_r <= lvl_r;
      end
   end

   assign slow_rise = lvl_r[0] & ~lvl_d_r[0];
   assign fast_rise = lvl_r[1] & ~lvl_d_r[1];
   assign ext_lvl = lvl_r[2];

   // ------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------
   logic [3:0] mode_r, mode_nxt;
   logic [1:0] src_r, src_nxt, ratio0_r, ratio0_nxt, ratio1_r, ratio1_nxt;
   logic [1:0] run_r, run_nxt, pwm_r, pwm_nxt, mmask_r, mmask_nxt, umask_r, umask_nxt;
   logic [7:0] rld0_r, rld0_nxt, rld1_r, rld1_nxt, cmp0_r, cmp0_nxt, cmp1_r, cmp1_nxt;
   logic cascade, event_count_select, filt_en, pol, reload0, reload1_own;

   assign cascade = mode_r[dpt_pkg::MODE_CASCADE_BIT];
   assign event_count_select = mode_r[dpt_pkg::MODE_EVENT_BIT];
   assign filt_en = mode_r[dpt_pkg::MODE_FILTER_BIT];
   assign pol = mode_r[dpt_pkg::MODE_POL_BIT];
   assign reload0 = dpt_wr1(wr_i, addr_i, dpt_pkg::ADR_T0CTL,
                            wdata_i[dpt_pkg::CTL_RELOAD_BIT]);
   assign reload1_own = dpt_wr1(wr_i, addr_i, dpt_pkg::ADR_T1CTL,
                                wdata_i[dpt_pkg::CTL_RELOAD_BIT]);

   // Plain storing writes of all read/write fields
   always_comb
   begin
      mode_nxt = mode_r;
      src_nxt = src_r;
      ratio0_nxt = ratio0_r;
      ratio1_nxt = ratio1_r;
      run_nxt = run_r;
      pwm_nxt = pwm_r;
      mmask_nxt = mmask_r;
      umask_nxt = umask_r;
      rld0_nxt = rld0_r;
      rld1_nxt = rld1_r;
      cmp0_nxt = cmp0_r;
      cmp1_nxt = cmp1_r;
      if (wr_i)
      begin
         case (addr_i)
            dpt_pkg::ADR_MODE: mode_nxt = wdata_i;
            dpt_pkg::ADR_SRC: src_nxt = wdata_i[1:0];
            dpt_pkg::ADR_T0CTL:
            begin
               ratio0_nxt = wdata_i[dpt_pkg::CTL_RATIO_LSB +: 2];
               run_nxt[0] = wdata_i[dpt_pkg::CTL_RUN_BIT];
            end
            dpt_pkg::ADR_T1CTL:
            begin
               ratio1_nxt = wdata_i[dpt_pkg::CTL_RATIO_LSB +: 2];
               run_nxt[1] = wdata_i[dpt_pkg::CTL_RUN_BIT];
            end
            dpt_pkg::ADR_RLD0L: rld0_nxt[3:0] = wdata_i;
            dpt_pkg::ADR_RLD0H: rld0_nxt[7:4] = wdata_i;
            dpt_pkg::ADR_RLD1L: rld1_nxt[3:0] = wdata_i;
            dpt_pkg::ADR_RLD1H: rld1_nxt[7:4] = wdata_i;
            dpt_pkg::ADR_CMP0L: cmp0_nxt[3:0] = wdata_i;
            dpt_pkg::ADR_CMP0H: cmp0_nxt[7:4] = wdata_i;
            dpt_pkg::ADR_CMP1L: cmp1_nxt[3:0] = wdata_i;
            dpt_pkg::ADR_CMP1H: cmp1_nxt[7:4] = wdata_i;
            dpt_pkg::ADR_PWM: pwm_nxt = wdata_i[1:0];
            dpt_pkg::ADR_MMASK: mmask_nxt = wdata_i[1:0];
            dpt_pkg::ADR_UMASK: umask_nxt = wdata_i[1:0];
            default: mode_nxt = mode_r;
         endcase
      end
   end

   // Configuration storage, all cleared by reset
   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         mode_r <= dpt_pkg::NIB_RST;
         src_r <= dpt_pkg::PAIR_RST;
         ratio0_r <= dpt_pkg::PAIR_RST;
         ratio1_r <= dpt_pkg::PAIR_RST;
         run_r <= dpt_pkg::PAIR_RST;
         pwm_r <= dpt_pkg::PAIR_RST;
         mmask_r <= dpt_pkg::PAIR_RST;
         umask_r <= dpt_pkg::PAIR_RST;
         rld0_r <= dpt_pkg::BYTE_RST;
         rld1_r <= dpt_pkg::BYTE_RST;
         cmp0_r <= dpt_pkg::BYTE_RST;
         cmp1_r <= dpt_pkg::BYTE_RST;
      end
      else
      begin
         mode_r <= mode_nxt;
         src_r <= src_nxt;
         ratio0_r <= ratio0_nxt;
         ratio1_r <= ratio1_nxt;
         run_r <= run_nxt;
         pwm_r <= pwm_nxt;
         mmask_r <= mmask_nxt;
         umask_r <= umask_nxt;
         rld0_r <= rld0_nxt;
         rld1_r <= rld1_nxt;
         cmp0_r <= cmp0_nxt;
         cmp1_r <= cmp1_nxt;
      end
   end

   // ------------------------------------------------------------
   // Noise rejector and event edge
   // ------------------------------------------------------------
   dpt_pkg::dpt_flt_t flt_state_r, flt_state_nxt;
   logic [3:0] ref_div_r, ref_div_nxt;
   logic filt_r, filt_nxt, ev_lvl, ev_lvl_d_r, ref_fall, ev_edge;

   // Reference falls when its divider wraps on a slow tick
   assign ref_fall = slow_rise && (ref_div_r == dpt_pkg::REF_LAST);

   // Change taken at the second reference falling edge after it began
   always_comb
   begin
      ref_div_nxt = slow_rise ? ref_div_r + 4'h1 : ref_div_r;
      flt_state_nxt = flt_state_r;
      filt_nxt = filt_r;
      if (!filt_en)
      begin
         filt_nxt = ext_lvl;
         flt_state_nxt = dpt_pkg::FLT_STABLE;
      end
      else
      begin
         case (flt_state_r)
            dpt_pkg::FLT_STABLE:
               if (ext_lvl != filt_r && ref_fall)
                  flt_state_nxt = dpt_pkg::FLT_ONE;
            dpt_pkg::FLT_ONE:
               if (ext_lvl == filt_r)
                  flt_state_nxt = dpt_pkg::FLT_STABLE;
               else if (ref_fall)
               begin
                  filt_nxt = ext_lvl;
                  flt_state_nxt = dpt_pkg::FLT_STABLE;
               end
            default: flt_state_nxt = dpt_pkg::FLT_STABLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         ref_div_r <= dpt_pkg::NIB_RST;
         flt_state_r <= dpt_pkg::FLT_STABLE;
         filt_r <= 1'b0;
         ev_lvl_d_r <= 1'b0;
      end
      else
      begin
         ref_div_r <= ref_div_nxt;
         flt_state_r <= flt_state_nxt;
         filt_r <= filt_nxt;
         ev_lvl_d_r <= ev_lvl;
      end
   end

   // Filtered or direct level, edge by polarity, only in event mode
   assign ev_lvl = filt_en ? filt_r : ext_lvl;
   assign ev_edge = event_count_select &&
                    (pol ? (ev_lvl & ~ev_lvl_d_r) : (~ev_lvl & ev_lvl_d_r));

   // ------------------------------------------------------------
   // Prescalers and down counters
   // ------------------------------------------------------------
   logic [7:0] p0_r, p0_nxt, p1_r, p1_nxt, cnt0_r, cnt0_nxt, cnt1_r, cnt1_nxt;
   logic src0_tick, src1_tick, p0_tick, p1_tick, t0_step, t1_step, t0_uf, t1_uf;
   logic reload1, m0, m1, pwm1_eff;

   // Source choice, ignored where the mode makes it irrelevant
   assign src0_tick = src_r[0] ? fast_rise : slow_rise;
   assign src1_tick = src_r[1] ? fast_rise : slow_rise;
   assign p0_tick = run_r[0] && src0_tick && dpt_ratio_hit(p0_r, ratio0_r);
   assign p1_tick = run_r[1] && src1_tick && dpt_ratio_hit(p1_r, ratio1_r);
   assign t0_step = run_r[0] && (event_count_select ? ev_edge : p0_tick);
   assign t1_step = cascade ? t0_uf : p1_tick;
   assign t0_uf = t0_step && (cnt0_r == dpt_pkg::BYTE_RST);
   assign t1_uf = t1_step && (cnt1_r == dpt_pkg::BYTE_RST);
   assign reload1 = cascade ? reload0 : reload1_own;
   assign pwm1_eff = cascade ? pwm_r[0] : pwm_r[1];

   // Count down, reload on underflow or strobe
   always_comb
   begin
      p0_nxt = (run_r[0] && src0_tick) ? p0_r + 8'h01 : p0_r;
      p1_nxt = (run_r[1] && src1_tick) ? p1_r + 8'h01 : p1_r;
      cnt0_nxt = cnt0_r;
      cnt1_nxt = cnt1_r;
      if (reload0)
      begin
         cnt0_nxt = rld0_r;
         p0_nxt = dpt_pkg::BYTE_RST;
      end
      else if (t0_step)
         cnt0_nxt = t0_uf ? rld0_r : cnt0_r - 8'h01;
      if (reload1)
      begin
         cnt1_nxt = rld1_r;
         p1_nxt = dpt_pkg::BYTE_RST;
      end
      else if (t1_step)
         cnt1_nxt = t1_uf ? rld1_r : cnt1_r - 8'h01;
   end

   // Matches in PWM mode; cascaded match uses all sixteen bits
   assign m0 = !cascade && pwm_r[0] && t0_step && !reload0 && (cnt0_nxt == cmp0_r);
   assign m1 = cascade ? (pwm_r[0] && t0_step && !reload0 &&
                          ({cnt1_nxt, cnt0_nxt} == {cmp1_r, cmp0_r}))
                       : (pwm_r[1] && t1_step && !reload1 && (cnt1_nxt == cmp1_r));

   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         p0_r <= dpt_pkg::BYTE_RST;
         p1_r <= dpt_pkg::BYTE_RST;
         cnt0_r <= dpt_pkg::BYTE_RST;
         cnt1_r <= dpt_pkg::BYTE_RST;
      end
      else
      begin
         p0_r <= p0_nxt;
         p1_r <= p1_nxt;
         cnt0_r <= cnt0_nxt;
         cnt1_r <= cnt1_nxt;
      end
   end

   // ------------------------------------------------------------
   // Flags, outputs and read port
   // ------------------------------------------------------------
   logic [1:0] uflag_r, uflag_nxt, mflag_r, mflag_nxt;
   logic out0_r, out0_nxt, out1_r, out1_nxt, irq_nxt, irq_r;
   logic [3:0] rdata_r, rdata_nxt;
   logic [1:0] uclr, mclr;

   assign uclr = (wr_i && addr_i == dpt_pkg::ADR_UFLAG) ? wdata_i[1:0] : 2'h0;
   assign mclr = (wr_i && addr_i == dpt_pkg::ADR_MFLAG) ? wdata_i[1:0] : 2'h0;

   // Sticky flags, event wins over clear; outputs set/clear or toggle
   always_comb
   begin
      uflag_nxt = (uflag_r & ~uclr) | {t1_uf, t0_uf};
      mflag_nxt = (mflag_r & ~mclr) | {m1, m0};
      irq_nxt = |((uflag_nxt & umask_r) | (mflag_nxt & mmask_r));
      out0_nxt = out0_r;
      out1_nxt = out1_r;
      if (pwm_r[0])
         out0_nxt = t0_uf ? 1'b1 : (m0 ? 1'b0 : out0_r);
      else if (t0_uf)
         out0_nxt = ~out0_r;
      if (pwm1_eff)
         out1_nxt = t1_uf ? 1'b1 : (m1 ? 1'b0 : out1_r);
      else if (t1_uf)
         out1_nxt = ~out1_r;
      rdata_nxt = dpt_pkg::NIB_RST;
      if (rd_i)
      begin
         case (addr_i)
            dpt_pkg::ADR_MODE: rdata_nxt = mode_r;
            dpt_pkg::ADR_SRC: rdata_nxt = {2'h0, src_r};
            dpt_pkg::ADR_T0CTL: rdata_nxt = {ratio0_r, 1'b0, run_r[0]};
            dpt_pkg::ADR_T1CTL: rdata_nxt = {ratio1_r, 1'b0, run_r[1]};
            dpt_pkg::ADR_RLD0L: rdata_nxt = rld0_r[3:0];
            dpt_pkg::ADR_RLD0H: rdata_nxt = rld0_r[7:4];
            dpt_pkg::ADR_RLD1L: rdata_nxt = rld1_r[3:0];
            dpt_pkg::ADR_RLD1H: rdata_nxt = rld1_r[7:4];
            dpt_pkg::ADR_CNT0L: rdata_nxt = cnt0_r[3:0];
            dpt_pkg::ADR_CNT0H: rdata_nxt = cnt0_r[7:4];
            dpt_pkg::ADR_CNT1L: rdata_nxt = cnt1_r[3:0];
            dpt_pkg::ADR_CNT1H: rdata_nxt = cnt1_r[7:4];
            dpt_pkg::ADR_CMP0L: rdata_nxt = cmp0_r[3:0];
            dpt_pkg::ADR_CMP0H: rdata_nxt = cmp0_r[7:4];
            dpt_pkg::ADR_CMP1L: rdata_nxt = cmp1_r[3:0];
            dpt_pkg::ADR_CMP1H: rdata_nxt = cmp1_r[7:4];
            dpt_pkg::ADR_PWM: rdata_nxt = {2'h0, pwm_r};
            dpt_pkg::ADR_MMASK: rdata_nxt = {2'h0, mmask_r};
            dpt_pkg::ADR_UMASK: rdata_nxt = {2'h0, umask_r};
            dpt_pkg::ADR_MFLAG: rdata_nxt = {2'h0, mflag_r};
            dpt_pkg::ADR_UFLAG: rdata_nxt = {2'h0, uflag_r};
            default: rdata_nxt = dpt_pkg::NIB_RST;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         uflag_r <= dpt_pkg::PAIR_RST;
         mflag_r <= dpt_pkg::PAIR_RST;
         out0_r <= 1'b0;
         out1_r <= 1'b0;
         irq_r <= 1'b0;
         rdata_r <= dpt_pkg::NIB_RST;
      end
      else
      begin
         uflag_r <= uflag_nxt;
         mflag_r <= mflag_nxt;
         out0_r <= out0_nxt;
         out1_r <= out1_nxt;
         irq_r <= irq_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign rdata_o = rdata_r;
   assign t0_out_o = out0_r;
   assign t1_out_o = out1_r;
   assign int_request_o = irq_r;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);

   sequence seq_accept;
      filt_en && flt_state_r == dpt_pkg::FLT_ONE && ext_lvl != filt_r && ref_fall;
   endsequence
   sequence seq_arm;
      filt_en && flt_state_r == dpt_pkg::FLT_STABLE && ext_lvl != filt_r && ref_fall;
   endsequence

   AST_SLOW_DIV1: assert property (run_r[0] && !event_count_select && !src_r[0] &&
      ratio0_r == 2'h0 && slow_rise && !reload0 |=>
      cnt0_r == ($past(cnt0_r) == 8'h00 ? $past(rld0_r) : $past(cnt0_r) - 8'h01))
      else $error("timer 0 did not step on slow tick at ratio one");
   AST_RATIO4_HOLD: assert property (!event_count_select && ratio0_r == 2'h1 &&
      p0_r[1:0] != 2'h3 && !reload0 |=> $stable(cnt0_r))
      else $error("timer 0 stepped before fourth source tick");
   AST_EVT_ONLY: assert property (event_count_select && !ev_edge && !reload0 |=>
      $stable(cnt0_r))
      else $error("event mode counter moved without pin edge");
   AST_RELOAD: assert property (reload0 |=> cnt0_r == $past(rld0_r) &&
      ($past(cascade) ? cnt1_r == $past(rld1_r) : 1'b1))
      else $error("reload strobe did not preset counter");
   AST_CASCADE_HI: assert property (cascade && !reload1 && !t0_uf |=> $stable(cnt1_r))
      else $error("high byte moved without low byte underflow");
   AST_UF_FLAG: assert property (t0_uf |=> uflag_r[0])
      else $error("underflow flag not set");
   AST_W1C: assert property (uflag_r[0] && uclr[0] && !t0_uf |=> !uflag_r[0])
      else $error("write one did not clear underflow flag");
   AST_W0_KEEP: assert property (mflag_r[0] && wr_i && addr_i == dpt_pkg::ADR_MFLAG &&
      !wdata_i[0] |=> mflag_r[0])
      else $error("write zero cleared match flag");
   AST_RSVD_ZERO: assert property (rd_i && (addr_i == dpt_pkg::ADR_PWM ||
      addr_i == dpt_pkg::ADR_UFLAG || addr_i == dpt_pkg::ADR_MMASK) |=> rdata_o[3:2] == 2'h0)
      else $error("unused bits read nonzero");
   AST_FILT_ACCEPT: assert property (seq_accept |=> filt_r == $past(ext_lvl))
      else $error("filter missed second reference edge");
   AST_FILT_ARM: assert property (seq_arm |=> $stable(filt_r))
      else $error("filter took change at first reference edge");
   AST_MATCH: assert property (m0 |=> mflag_r[0] && cnt0_r == $past(cmp0_r))
      else $error("match flag without equal counter");
endmodule

// [test/dpt_pulse_src.sv]
// Behavioural event pulse source for the external count pin
`timescale 1ns/10ps
module dpt_pulse_src (
   input wire logic sys_clk_i,
   output logic pin_o
);
   // The pin idles high and never floats
   initial pin_o = 1'b1;
   // One low pulse of lo cycles, then high for gap cycles
   task automatic pulse(input int lo, input int gap);
      @(posedge sys_clk_i);
      pin_o <= 1'b0;
      repeat (lo) @(posedge sys_clk_i);
      pin_o <= 1'b1;
      repeat (gap) @(posedge sys_clk_i);
   endtask
endmodule

// [test/testbench.sv]
// Self-checking bench for the dual timer control block
`timescale 1ns/10ps
module testbench;
   typedef struct {logic [15:0] a; logic [3:0] d; logic [3:0] e;} dpt_row_t;
   logic sys_clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic slow_clock_i = 1'b0;
   logic fast_clock_i = 1'b0;
   logic pin;
   logic int_request_o;
   logic t0_out_o;
   logic t1_out_o;
   logic [15:0] addr_i = 16'h0000;
   logic [3:0] wdata_i = 4'h0;
   logic [3:0] rdata_o;
   int n_mismatch = 0;
   int check_count = 0;
   int dv [4] = '{1, 4, 32, 256};
   // Zero data means read only; reset values come first
   dpt_row_t rows [19] = '{'{16'hFFC0, 4'h0, 4'h0}, '{16'hFFC2, 4'h0, 4'h0},
      '{16'hFFC3, 4'h0, 4'h0}, '{16'hFFD8, 4'h0, 4'h0}, '{16'hFFE0, 4'h0, 4'h0},
      '{16'hFFE1, 4'h0, 4'h0}, '{16'hFFF0, 4'h0, 4'h0}, '{16'hFFF1, 4'h0, 4'h0},
      '{16'hFFD3, 4'h0, 4'h0}, '{16'hFFC0, 4'hF, 4'hF}, '{16'hFFC2, 4'h3, 4'h3},
      '{16'hFFC3, 4'hE, 4'hC}, '{16'hFFD8, 4'hF, 4'h3}, '{16'hFFE0, 4'hF, 4'h3},
      '{16'hFFE1, 4'hF, 4'h3}, '{16'hFFD3, 4'hA, 4'hA}, '{16'hFFD4, 4'h5, 4'h5},
      '{16'hFFF0, 4'hF, 4'h0}, '{16'hFFC5, 4'hF, 4'h0}};
   dpt_timer_core dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .slow_clock_i(slow_clock_i),
      .fast_clock_i(fast_clock_i), .external_count_pin_i(pin), .rdata_o(rdata_o),
      .t0_out_o(t0_out_o), .t1_out_o(t1_out_o), .int_request_o(int_request_o));
   dpt_pulse_src src (.sys_clk_i(sys_clk_i), .pin_o(pin));
   // 250 MHz system clock
   initial forever #2 sys_clk_i = ~sys_clk_i;
   task automatic chk(input logic [15:0] id, input logic [3:0] s, input logic [3:0] e);
      check_count++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("MISMATCH item %h expected %h seen %h", id, e, s);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [3:0] d);
      @(posedge sys_clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge sys_clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rc(input logic [15:0] a, input logic [3:0] e);
      @(posedge sys_clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge sys_clk_i);
      rd_i <= 1'b0;
      #1 chk(a, rdata_o, e);
   endtask
   // n rising edges on one oscillator, ten system cycles apart
   task automatic edges(input logic f, input int n);
      repeat (2 * n)
      begin
         repeat (5) @(posedge sys_clk_i);
         if (f) fast_clock_i <= ~fast_clock_i;
         else slow_clock_i <= ~slow_clock_i;
      end
      repeat (8) @(posedge sys_clk_i);
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Watchdog against a hang
   initial
   begin
      #200000;
      n_mismatch++;
      end_sim();
   end
   // Main sequence
   initial
   begin
      repeat (2) @(posedge sys_clk_i);
      reset_n_i <= 1'b1;
      foreach (rows[i])
      begin
         if (rows[i].d !== 4'h0) wr(rows[i].a, rows[i].d);
         rc(rows[i].a, rows[i].e);
      end
      $display("register table done");
      @(posedge sys_clk_i);
      reset_n_i <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
      reset_n_i <= 1'b1;
      rc(16'hFFC0, 4'h0);
      rc(16'hFFE1, 4'h0);
      $display("mid-run reset done");
      // Fast oscillator is fitted on this bench, so selecting it is legal
      wr(16'hFFC7, 4'h1);
      for (int i = 0; i < 4; i++)
      begin
         wr(16'hFFC2, {3'h0, i[0]});
         wr(16'hFFC3, {i[1:0], 2'h3});
         edges(i[0], 2 * dv[i]);
         wr(16'hFFC3, {i[1:0], 2'h0});
         rc(16'hFFCC, 4'hE);
         rc(16'hFFCD, 4'h0);
      end
      $display("prescaler done");
      wr(16'hFFC6, 4'h5);
      wr(16'hFFC7, 4'h0);
      wr(16'hFFC0, 4'h4);
      wr(16'hFFC3, 4'hF);
      repeat (3) src.pulse(3, 12);
      rc(16'hFFCC, 4'h2);
      wr(16'hFFC0, 4'h5);
      repeat (3) src.pulse(3, 12);
      rc(16'hFFCC, 4'h5);
      rc(16'hFFF1, 4'h1);
      chk(16'h0001, {3'h0, int_request_o}, 4'h0);
      wr(16'hFFE1, 4'h1);
      repeat (2) @(posedge sys_clk_i);
      #1 chk(16'h0001, {3'h0, int_request_o}, 4'h1);
      wr(16'hFFF1, 4'h0);
      rc(16'hFFF1, 4'h1);
      wr(16'hFFF1, 4'h1);
      rc(16'hFFF1, 4'h0);
      chk(16'h0001, {3'h0, int_request_o}, 4'h0);
      wr(16'hFFC0, 4'h6);
      fork
         edges(1'b0, 130);
         begin
            src.pulse(8, 400);
            src.pulse(400, 400);
         end
      join
      rc(16'hFFCC, 4'h4);
      $display("event counter done");
      wr(16'hFFC3, 4'h0);
      wr(16'hFFC6, 4'h0);
      wr(16'hFFC8, 4'h1);
      wr(16'hFFC0, 4'h8);
      // Timer 0 back on the slow clock, timer 1 source set but ignored
      wr(16'hFFC2, 4'h2);
      wr(16'hFFC4, 4'hC);
      wr(16'hFFC3, 4'h3);
      edges(1'b0, 1);
      rc(16'hFFCE, 4'h0);
      edges(1'b0, 1);
      rc(16'hFFCE, 4'h1);
      rc(16'hFFF1, 4'h3);
      chk(16'h0002, {3'h0, t1_out_o}, 4'h1);
      $display("cascade done");
      // Timer 0 alone in PWM mode: reload 3, compare 1
      wr(16'hFFC0, 4'h0);
      wr(16'hFFF1, 4'h3);
      wr(16'hFFC6, 4'h3);
      wr(16'hFFD2, 4'h1);
      wr(16'hFFD8, 4'h1);
      wr(16'hFFC3, 4'h3);
      edges(1'b0, 2);
      rc(16'hFFF0, 4'h1);
      chk(16'h0001, {3'h0, int_request_o}, 4'h0);
      chk(16'h0003, {3'h0, t0_out_o}, 4'h0);
      wr(16'hFFE0, 4'h1);
      repeat (2) @(posedge sys_clk_i);
      #1 chk(16'h0001, {3'h0, int_request_o}, 4'h1);
      wr(16'hFFF0, 4'h2);
      rc(16'hFFF0, 4'h1);
      wr(16'hFFF0, 4'h1);
      rc(16'hFFF0, 4'h0);
      chk(16'h0001, {3'h0, int_request_o}, 4'h0);
      edges(1'b0, 2);
      rc(16'hFFCC, 4'h3);
      chk(16'h0003, {3'h0, t0_out_o}, 4'h1);
      chk(16'h0001, {3'h0, int_request_o}, 4'h1);
      $display("pwm done");
      end_sim();
   end
endmodule
